// File: scpm_top.sv
// pin routing, spi byte engine and data FIFOs of one serial unit
// assumes uart and two-wire engines sit outside and meet this block at plain ports;
// mode and control inputs come from registers on the same clock
`timescale 1ns/1ps
`include "scpm_regs.svh"

// ---------------------------------------------------------------
// small synchronous FIFO
// ---------------------------------------------------------------
module scpm_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = `SCPM_FIFO_DEPTH
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic [WIDTH-1:0] in_data,
	input wire logic in_valid,
	output logic in_ready,
	output logic [WIDTH-1:0] out_data,
	output logic out_valid,
	input wire logic out_ready
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_q, rd_q;
	logic [AW:0] cnt_q, cnt_d;
	logic room_q, avail_q, push, pop;

	assign push = in_valid & room_q;
	assign pop = out_ready & avail_q;
	assign in_ready = room_q;
	assign out_valid = avail_q;
	assign out_data = mem[rd_q];

	// storage
	always_ff @(posedge clock) begin
		if (push) begin
			mem[wr_q] <= in_data;
		end
	end

	// occupancy
	always_comb begin
		cnt_d = cnt_q;
		if (push && !pop) begin
			cnt_d = cnt_q + (AW+1)'(1);
		end else if (pop && !push) begin
			cnt_d = cnt_q - (AW+1)'(1);
		end
	end

	// pointers and flags
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			wr_q <= '0;
			rd_q <= '0;
			cnt_q <= '0;
			room_q <= 1'b1;
			avail_q <= 1'b0;
		end else begin
			if (push) wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + AW'(1);
			if (pop) rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + AW'(1);
			cnt_q <= cnt_d;
			room_q <= (cnt_d != (AW+1)'(DEPTH));
			avail_q <= (cnt_d != '0);
		end
	end
endmodule // scpm_fifo

// ---------------------------------------------------------------
// serial unit top
// ---------------------------------------------------------------
module scpm_top import scpm_pkg::*; #(
	parameter bit IS_FIRST = 1'b1,
	parameter int HALF_CYC = `SCPM_SPI_HALF_CYC,
	parameter int DEPTH = `SCPM_FIFO_DEPTH
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic [1:0] serial_unit_op_select,
	input wire logic spi_master_role,
	input wire logic uart_flow_en,
	input wire logic pb1_in,
	output logic pb1_out,
	output logic pb1_oe,
	input wire logic pb2_in,
	output logic pb2_out,
	output logic pb2_oe,
	input wire logic pb3_in,
	output logic pb3_out,
	output logic pb3_oe,
	input wire logic pb4_in,
	output logic pb4_out,
	output logic pb4_oe,
	input wire logic [7:0] tx_data,
	input wire logic tx_valid,
	output logic tx_ready,
	output logic [7:0] rx_data,
	output logic rx_valid,
	input wire logic rx_ready,
	output logic rx_byte_event,
	output logic rx_overrun,
	input wire logic uart_txd,
	input wire logic uart_rts_n,
	output logic uart_rxd,
	output logic uart_cts_n,
	input wire logic [7:0] uart_rx_byte,
	input wire logic uart_rx_strobe,
	output logic [7:0] uart_tx_byte,
	output logic uart_tx_avail,
	input wire logic uart_tx_take,
	input wire logic twi_sda_low,
	input wire logic twi_scl_low,
	output logic twi_sda_in,
	output logic twi_scl_in
);
	localparam logic [7:0] HALF = 8'(HALF_CYC);
	scpm_mode_t mode;
	scpm_spi_st_t st_q;
	logic [3:0] pin_s1_q, pin_s2_q;
	logic sclk_last_q, sclk_q, in_bit_q, rx_push;
	logic [7:0] shift_q, div_q, rx_in;
	logic [2:0] bit_q;
	logic spi_on, fifo_on, sclk_rise, sclk_fall, spi_pop;
	logic txf_valid, txf_pop, rxf_ready, rxf_valid, rxf_in_valid;
	logic [7:0] txf_data;
	logic [3:0] out_d, oe_d;

	// uart code on the second unit reads as disabled
	always_comb begin
		mode = scpm_mode_t'(serial_unit_op_select);
		if (mode == SCPM_UART && !IS_FIRST) mode = SCPM_OFF;
	end
	assign spi_on = (mode == SCPM_SPI);
	assign fifo_on = (mode == SCPM_SPI) || (mode == SCPM_UART);

	// two-flop synchronisers on pins 1 to 4
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			pin_s1_q <= 4'h0;
			pin_s2_q <= 4'h0;
		end else begin
			pin_s1_q <= {pb4_in, pb3_in, pb2_in, pb1_in};
			pin_s2_q <= pin_s1_q;
		end
	end

	// serial clock edges: own divider as master, pin 3 as slave
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			sclk_last_q <= 1'b0;
		end else begin
			sclk_last_q <= spi_master_role ? sclk_q : pin_s2_q[2];
		end
	end
	assign sclk_rise = spi_master_role ? (div_q == HALF - 8'h01 && !sclk_q)
		: (pin_s2_q[2] && !sclk_last_q);
	assign sclk_fall = spi_master_role ? (div_q == HALF - 8'h01 && sclk_q)
		: (!pin_s2_q[2] && sclk_last_q);

	// transmit and receive FIFOs
	assign txf_pop = fifo_on && (spi_on ? spi_pop : uart_tx_take);
	assign rxf_in_valid = fifo_on && (spi_on ? rx_push : uart_rx_strobe);
	assign rx_in = spi_on ? {shift_q[6:0], in_bit_q} : uart_rx_byte;

	// software writes one byte at a time and may poll ready instead of waiting
	scpm_fifo #(.WIDTH(8), .DEPTH(DEPTH)) u_txf (
		.clock(clock), .rst(rst),
		.in_data(tx_data), .in_valid(tx_valid && fifo_on), .in_ready(tx_ready),
		.out_data(txf_data), .out_valid(txf_valid), .out_ready(txf_pop)
	);
	// receive side, read directly by software when polling
	scpm_fifo #(.WIDTH(8), .DEPTH(DEPTH)) u_rxf (
		.clock(clock), .rst(rst),
		.in_data(rx_in), .in_valid(rxf_in_valid), .in_ready(rxf_ready),
		.out_data(rx_data), .out_valid(rxf_valid), .out_ready(rx_ready)
	);
	assign rx_valid = rxf_valid;

	// master start waits for a byte and for room to keep the answer
	assign spi_pop = (st_q == SCPM_ST_IDLE) && spi_on && txf_valid
		&& (spi_master_role ? rxf_ready : !pin_s2_q[3]);

	// spi byte engine, mode 0, msb first
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			st_q <= SCPM_ST_IDLE;
			shift_q <= 8'h00;
			bit_q <= 3'h0;
			in_bit_q <= 1'b0;
			rx_push <= 1'b0;
		end else begin
			rx_push <= 1'b0;
			unique case (st_q)
				SCPM_ST_IDLE: begin
					bit_q <= 3'h0;
					if (spi_pop) begin
						shift_q <= txf_data;
						st_q <= SCPM_ST_SHIFT;
					end else if (spi_on && !spi_master_role && !pin_s2_q[3]) begin
						shift_q <= 8'h00; // underrun: slave sends zeros
						st_q <= SCPM_ST_SHIFT;
					end
				end
				SCPM_ST_SHIFT: begin
					if (!spi_on || (!spi_master_role && pin_s2_q[3])) begin
						st_q <= SCPM_ST_IDLE;
					end else if (sclk_rise) begin
						in_bit_q <= pin_s2_q[1];
					end else if (sclk_fall) begin
						bit_q <= bit_q + 3'h1;
						if (bit_q == 3'(`SCPM_BYTE_BITS - 1)) begin
							rx_push <= 1'b1;
							st_q <= SCPM_ST_DONE;
						end else begin
							shift_q <= {shift_q[6:0], in_bit_q};
						end
					end
				end
				SCPM_ST_DONE: begin
					shift_q <= {shift_q[6:0], in_bit_q};
					if (spi_master_role || pin_s2_q[3]) st_q <= SCPM_ST_IDLE;
					else if (spi_pop) begin
						shift_q <= txf_data;
						st_q <= SCPM_ST_SHIFT;
					end
				end
				default: st_q <= SCPM_ST_IDLE;
			endcase
		end
	end

	// master clock divider, idles low between bytes
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			div_q <= 8'h00;
			sclk_q <= 1'b0;
		end else if (st_q == SCPM_ST_SHIFT && spi_master_role && spi_on) begin
			div_q <= (div_q == HALF - 8'h01) ? 8'h00 : div_q + 8'h01;
			if (div_q == HALF - 8'h01) sclk_q <= !sclk_q;
		end else begin
			div_q <= 8'h00;
			sclk_q <= 1'b0;
		end
	end

	// per-mode pin drive; open-drain pins enable only to pull low
	always_comb begin
		out_d = 4'h0;
		oe_d = 4'h0;
		unique case (mode)
			SCPM_SPI: begin
				out_d[0] = shift_q[7];
				oe_d[0] = 1'b1;
				out_d[2] = sclk_q;
				oe_d[2] = spi_master_role;
			end
			SCPM_TWI: begin
				oe_d[0] = twi_sda_low;
				oe_d[1] = twi_scl_low;
			end
			SCPM_UART: begin
				out_d[0] = uart_txd;
				oe_d[0] = 1'b1;
				out_d[3] = uart_rts_n;
				oe_d[3] = uart_flow_en;
			end
			SCPM_OFF: begin
				oe_d = 4'h0;
			end
		endcase
	end

	// registered pin outputs
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			{pb4_out, pb3_out, pb2_out, pb1_out} <= 4'h0;
			{pb4_oe, pb3_oe, pb2_oe, pb1_oe} <= 4'h0;
		end else begin
			{pb4_out, pb3_out, pb2_out, pb1_out} <= out_d;
			{pb4_oe, pb3_oe, pb2_oe, pb1_oe} <= oe_d;
		end
	end

	// registered views for the outside engines and events
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			uart_rxd <= 1'b1;
			uart_cts_n <= 1'b0;
			uart_tx_byte <= 8'h00;
			uart_tx_avail <= 1'b0;
			twi_sda_in <= 1'b1;
			twi_scl_in <= 1'b1;
			rx_byte_event <= 1'b0;
			rx_overrun <= 1'b0;
		end else begin
			uart_rxd <= (mode == SCPM_UART) ? pin_s2_q[1] : 1'b1;
			uart_cts_n <= (mode == SCPM_UART && uart_flow_en) ? pin_s2_q[2] : 1'b0;
			uart_tx_byte <= txf_data;
			uart_tx_avail <= (mode == SCPM_UART) && txf_valid && !uart_tx_take;
			twi_sda_in <= (mode == SCPM_TWI) ? pin_s2_q[0] : 1'b1;
			twi_scl_in <= (mode == SCPM_TWI) ? pin_s2_q[1] : 1'b1;
			rx_byte_event <= rxf_in_valid && rxf_ready && mode != SCPM_OFF;
			if (mode == SCPM_OFF) rx_overrun <= 1'b0;
			else if (rxf_in_valid && !rxf_ready) rx_overrun <= 1'b1;
		end
	end
endmodule // scpm_top

// File: scpm_regs.svh
// constants for the serial unit mode and pin block: mode codes and timing counts
// assumes a single 50 MHz system clock; included by bare name
//
// Notes on behaviour
// - each unit runs SPI as master or slave, chosen by a role input
// - two-wire mode is master only; no two-wire slave logic exists
// - UART exists only on the first unit; the second treats it as disabled
// - FIFOs serve SPI and UART modes, never two-wire mode
// - FIFOs let software move one byte at a time per event
// - software may poll the FIFO data ports directly without events
// - pins 1 to 4 follow the per-mode table for SPI, two-wire and UART
// - mode field: 0 disabled, 1 UART, 2 SPI, 3 two-wire
`ifndef SCPM_REGS_SVH
`define SCPM_REGS_SVH

// ---------------------------------------------------------------
// mode field
// ---------------------------------------------------------------
`define SCPM_MODE_W 2
`define SCPM_MODE_OFF 2'h0
`define SCPM_MODE_UART 2'h1
`define SCPM_MODE_SPI 2'h2
`define SCPM_MODE_TWI 2'h3

// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define SCPM_CLK_MHZ 50
`define SCPM_SPI_HALF_NS 80
`define SCPM_SPI_HALF_CYC ((`SCPM_SPI_HALF_NS * `SCPM_CLK_MHZ) / 1000)
`define SCPM_BYTE_BITS 8
`define SCPM_FIFO_DEPTH 4

`endif

// File: scpm_pkg.sv
// types for the serial unit mode and pin block
// assumes scpm_regs.svh is on the include path
`include "scpm_regs.svh"

package scpm_pkg;

	// operating mode as held in the two-bit field
	typedef enum logic [1:0] {
		SCPM_OFF = `SCPM_MODE_OFF,
		SCPM_UART = `SCPM_MODE_UART,
		SCPM_SPI = `SCPM_MODE_SPI,
		SCPM_TWI = `SCPM_MODE_TWI
	} scpm_mode_t;

	// spi byte engine
	typedef enum logic [1:0] {
		SCPM_ST_IDLE = 2'b00,
		SCPM_ST_SHIFT = 2'b01,
		SCPM_ST_DONE = 2'b10
	} scpm_spi_st_t;

endpackage : scpm_pkg

// File: scpm_top_assertions.sv
// checker for pin drive, events and fifo flags of the first serial unit
// assumes one clock domain and the first unit, where uart is allowed
`timescale 1ns/1ps
module scpm_top_assertions import scpm_pkg::*; (
	input wire logic clock,
	input wire logic rst,
	input wire logic [1:0] serial_unit_op_select,
	input wire logic spi_master_role,
	input wire logic uart_flow_en,
	input wire logic pb1_out,
	input wire logic pb1_oe,
	input wire logic pb2_out,
	input wire logic pb2_oe,
	input wire logic pb3_oe,
	input wire logic pb4_oe,
	input wire logic rx_byte_event,
	input wire logic rx_valid,
	input wire logic rx_overrun,
	input wire logic twi_sda_in,
	input wire logic twi_scl_in
);
	// ---------------------------------------------------------------
	// pins and events per mode
	// ---------------------------------------------------------------
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	wire [1:0] m = serial_unit_op_select;
	off_no_drive_a:
	assert property ((m == SCPM_OFF)[*4] |-> !(pb1_oe | pb2_oe | pb3_oe | pb4_oe))
		else $error("pin driven while off");
	off_quiet_a:
	assert property ((m == SCPM_OFF)[*4] |-> !rx_byte_event && !rx_overrun)
		else $error("event while off");
	uart_pins_a:
	assert property ((m == SCPM_UART)[*4] |-> pb1_oe && !pb2_oe && !pb3_oe)
		else $error("uart pin drive wrong");
	rts_flow_a:
	assert property ((m == SCPM_UART && $stable(uart_flow_en))[*4] |-> pb4_oe == uart_flow_en)
		else $error("rts drive wrong");
	spi_master_pins_a:
	assert property ((m == SCPM_SPI && spi_master_role)[*4] |-> pb1_oe && pb3_oe && !pb2_oe && !pb4_oe)
		else $error("spi master pins wrong");
	spi_slave_pins_a:
	assert property ((m == SCPM_SPI && !spi_master_role)[*4] |-> !(pb2_oe | pb3_oe | pb4_oe))
		else $error("spi slave pins wrong");
	twi_open_drain_a:
	assert property ((m == SCPM_TWI)[*4] |-> !pb1_out && !pb2_out && !pb3_oe && !pb4_oe && !rx_byte_event)
		else $error("two-wire pins wrong");
	twi_idle_high_a:
	assert property ((m != SCPM_TWI)[*4] |-> twi_sda_in && twi_scl_in)
		else $error("two-wire view not idle");
	event_pulse_a:
	assert property (rx_byte_event |=> rx_valid && !rx_byte_event)
		else $error("byte event wrong");
	overrun_hold_a:
	assert property (rx_overrun && m != SCPM_OFF |=> rx_overrun)
		else $error("overrun dropped");
	cover property (rx_byte_event && m == SCPM_SPI);
	cover property (rx_overrun);
	cover property (m == SCPM_TWI && pb1_oe);
endmodule // scpm_top_assertions

bind scpm_top scpm_top_assertions u_chk (.clock(clock), .rst(rst),
	.serial_unit_op_select(serial_unit_op_select), .spi_master_role(spi_master_role),
	.uart_flow_en(uart_flow_en), .pb1_out(pb1_out), .pb1_oe(pb1_oe), .pb2_out(pb2_out),
	.pb2_oe(pb2_oe), .pb3_oe(pb3_oe), .pb4_oe(pb4_oe), .rx_byte_event(rx_byte_event),
	.rx_valid(rx_valid), .rx_overrun(rx_overrun), .twi_sda_in(twi_sda_in),
	.twi_scl_in(twi_scl_in));

// File: scpm_spi_dev.sv
// spi device on the far side of pins 1 to 3
// assumes clock idle low, sample on rise, shift on fall, msb first
`timescale 1ns/1ps
module scpm_spi_dev (
	input wire logic sclk,
	input wire logic mosi,
	input wire logic [7:0] seed_byte,
	output logic miso
);
	logic [7:0] sr;
	logic [7:0] rx;
	int n = 0;
	int k = 0;
	logic [7:0] got[$];
	// data line shows the current msb
	assign miso = sr[7];
	initial #1 sr = seed_byte;
	// capture on the rising edge
	always @(posedge sclk) rx = {rx[6:0], mosi};
	// shift on the falling edge; each frame answers seed plus frame count
	always @(negedge sclk) begin
		sr = sr << 1;
		n++;
		if (n == 8) begin
			got.push_back(rx);
			n = 0;
			k++;
			sr = seed_byte + 8'(k);
		end
	end
endmodule // scpm_spi_dev

// File: scpm_top_test.sv
// bench for the first serial unit: uart fifos, spi master and slave, two-wire pins
// assumes the spi device model drives pin 2 and watches pins 1 and 3
`timescale 1ns/1ps
`define CHK(a, b) chk(16'(a), 16'(b))
module scpm_top_test import scpm_pkg::*; ;
	// ---------------------------------------------------------------
	// stimulus, dut and far side
	// ---------------------------------------------------------------
	logic clock = 1'b0, rst = 1'b1, role = 1'b0, flow = 1'b0, sck = 1'b0, ssn = 1'b1;
	logic pb1_in = 1'b1, tx_valid = 1'b0, rx_ready = 1'b0, txd = 1'b1, strobe = 1'b0;
	logic take = 1'b0, sda_low = 1'b0, scl_low = 1'b0;
	logic [1:0] mode = 2'h0;
	logic [7:0] tx_data = 8'h00, rx_byte = 8'h00, seed = 8'h00, rx_data, tx_byte;
	logic pb2_in, pb1_out, pb1_oe, pb2_out, pb2_oe, pb3_out, pb3_oe, pb4_out, pb4_oe;
	logic tx_ready, rx_valid, rx_event, rx_overrun, rxd, cts_n, tx_avail, sda_in, scl_in;
	int errors = 0, total_checks = 0, k;
	int q[$];
	always #10 clock = ~clock;
	scpm_top #(.IS_FIRST(1'b1), .HALF_CYC(4), .DEPTH(4)) u_dut (.clock(clock), .rst(rst),
		.serial_unit_op_select(mode), .spi_master_role(role), .uart_flow_en(flow),
		.pb1_in(pb1_in), .pb1_out(pb1_out), .pb1_oe(pb1_oe), .pb2_in(pb2_in), .pb2_out(pb2_out),
		.pb2_oe(pb2_oe), .pb3_in(sck), .pb3_out(pb3_out), .pb3_oe(pb3_oe), .pb4_in(ssn),
		.pb4_out(pb4_out), .pb4_oe(pb4_oe), .tx_data(tx_data), .tx_valid(tx_valid),
		.tx_ready(tx_ready), .rx_data(rx_data), .rx_valid(rx_valid), .rx_ready(rx_ready),
		.rx_byte_event(rx_event), .rx_overrun(rx_overrun), .uart_txd(txd), .uart_rts_n(~txd),
		.uart_rxd(rxd), .uart_cts_n(cts_n), .uart_rx_byte(rx_byte), .uart_rx_strobe(strobe),
		.uart_tx_byte(tx_byte), .uart_tx_avail(tx_avail), .uart_tx_take(take),
		.twi_sda_low(sda_low), .twi_scl_low(scl_low), .twi_sda_in(sda_in), .twi_scl_in(scl_in));
	scpm_spi_dev u_dev (.sclk(role ? pb3_out : sck), .mosi(pb1_out), .seed_byte(seed),
		.miso(pb2_in));
	// compare, count and finish
	task automatic chk(input logic [15:0] a, input logic [15:0] b);
		total_checks++;
		if (a !== b) begin
			errors++;
			$display("ERROR at %0t: got %h expected %h", $time, a, b);
		end
	endtask
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// drivers change inputs on the falling edge
	task automatic wait_n(input int n);
		repeat (n) @(negedge clock);
	endtask
	task automatic setm(input logic [1:0] m);
		@(negedge clock);
		mode = m;
		wait_n(4);
	endtask
	task automatic push(input logic [7:0] b);
		@(negedge clock);
		tx_data = b;
		tx_valid = 1'b1;
		// ready is looked at while settled; the next rising edge then takes the byte
		while (tx_ready !== 1'b1) @(negedge clock);
		@(negedge clock);
		tx_valid = 1'b0;
	endtask
	task automatic pulse(ref logic s);
		@(negedge clock);
		s = 1'b1;
		@(negedge clock);
		s = 1'b0;
	endtask
	// pop the receive fifo against the expected queue
	task automatic drain();
		while (q.size() > 0) begin
			wait_n(1);
			`CHK({rx_valid, rx_data}, {1'b1, 8'(q.pop_front())});
			pulse(rx_ready);
		end
		wait_n(1);
		`CHK(rx_valid, 0);
	endtask
	initial begin
		void'($urandom(32'ha7a5_b3c4));
		seed = 8'($urandom());
		wait_n(5);
		rst = 1'b0;
		`CHK({tx_ready, rx_valid, pb1_oe, pb2_oe, pb3_oe, pb4_oe, rxd, cts_n}, 8'h82);
		flow = 1'($urandom());
		setm(SCPM_UART);
		for (k = 0; k < 4; k++) begin
			q.push_back(8'($urandom()));
			push(8'(q[k]));
		end
		wait_n(1);
		`CHK(tx_ready, 0);
		txd = 1'b0;
		wait_n(4);
		`CHK({pb1_out, pb4_oe, pb4_out, rxd, cts_n}, {1'b0, flow, 1'b1, pb2_in, 1'b0});
		while (q.size() > 0) begin
			wait_n(1);
			`CHK({tx_avail, tx_byte}, {1'b1, 8'(q.pop_front())});
			pulse(take);
		end
		wait_n(1);
		`CHK(tx_avail, 0);
		for (k = 0; k < 5; k++) begin
			rx_byte = 8'($urandom());
			if (k < 4)
				q.push_back(rx_byte);
			pulse(strobe);
		end
		wait_n(2);
		`CHK(rx_overrun, 1);
		drain();
		$display("uart fifo test done");
		setm(SCPM_OFF);
		`CHK(rx_overrun, 0);
		push(8'h5a);
		role = 1'b1;
		setm(SCPM_SPI);
		for (k = 0; k < 3; k++) begin
			q.push_back(8'($urandom()));
			push(8'(q[k]));
		end
		k = 0;
		while (u_dev.got.size() < 3 && k < 1000) begin
			wait_n(1);
			k++;
		end
		wait_n(4);
		for (k = 0; k < 3; k++) begin
			`CHK(u_dev.got[k], q[k]);
			q[k] = seed + k;
		end
		drain();
		$display("spi master test done");
		setm(SCPM_OFF);
		role = 1'b0;
		setm(SCPM_SPI);
		q.push_back(8'($urandom()));
		push(8'(q[0]));
		ssn = 1'b0;
		wait_n(4);
		repeat (8) begin
			#80 sck = 1'b1;
			#80 sck = 1'b0;
		end
		#80 ssn = 1'b1;
		wait_n(4);
		`CHK(u_dev.got[3], q[0]);
		q[0] = seed + 3;
		drain();
		$display("spi slave test done");
		setm(SCPM_TWI);
		sda_low = 1'b1;
		scl_low = 1'b1;
		pb1_in = 1'b0;
		wait_n(4);
		`CHK({pb1_oe, pb2_oe, pb1_out, pb2_out, sda_in, scl_in}, {5'h18, pb2_in});
		sda_low = 1'b0;
		wait_n(4);
		`CHK({pb1_oe, pb2_oe}, 2'h1);
		$display("two-wire test done");
		end_of_test();
	end
	// watchdog against a hang
	initial begin
		#400000;
		errors++;
		end_of_test();
	end
endmodule // scpm_top_test
